// ===== servo_cmd_regs.svh
// register map, command codes, keys, masks and timing of the command handler
`ifndef SERVO_CMD_REGS_SVH
`define SERVO_CMD_REGS_SVH
`define OFS_CMD        8'h00
`define OFS_DATA       8'h04
`define OFS_GO         8'h08
`define OFS_REPLY      8'h0C
`define OFS_ASCII_HI   8'h10
`define OFS_ASCII_LO   8'h14
`define OFS_STATE      8'h18
`define CMD_RD_IO      8'h12
`define DN_OUT_DEV     8'h80
`define CMD_WR_DI      8'h92
`define DN_COMM_DI     8'h60
`define DN_TEST_DI     8'h00
`define CMD_DIO_EN     8'h90
`define DN_DI_DIS      8'h00
`define DN_DI_EN       8'h10
`define DN_DO_DIS      8'h03
`define DN_DO_EN       8'h13
`define CMD_TEST_SEL   8'h8B
`define DN_TEST_SEL    8'h00
`define CMD_RD_STAT    8'h00
`define DN_TEST_MODE   8'h12
`define CMD_POS_CTL    8'hA0
`define DN_POS_CTL     8'h41
`define KEY_DIO        32'h0000_1EA5
`define SEL_CANCEL     32'h0000_0000
`define SEL_JOG        32'h0000_0001
`define SEL_POS        32'h0000_0002
`define SEL_FORCED     32'h0000_0004
`define DATA_STOP      32'h5354_4F50
`define DATA_GO        32'h4730_2020
`define DATA_CLR       32'h434C_5220
`define OUT_MASK       32'h8E00_FFBF
`define IN_MASK        32'h3810_FFFF
`define STROKE_MASK    32'h0000_0006
`define COMM_LOSS_NS   500000000
`define PCLK_PERIOD_NS 5
`endif

// ===== servo_cmd_pkg.sv
// types shared by the command handler
package servo_cmd_pkg;
   typedef enum logic [2:0] {
      TM_NORMAL    = 3'b000,
      TM_JOG       = 3'b001,
      TM_POS       = 3'b010,
      TM_MOTORLESS = 3'b011,
      TM_FORCED    = 3'b100
   } test_mode_t;
endpackage

// ===== servo_io_test_cmd_handler.sv
// slave-station i/o and test-operation command handler behind an apb port
//
// Summary of operation
// R1: cmd 12/80 returns output device word
// R2: output bits 0-5 and 7 mapped
// R3: output bits 8-15 mapped
// R4: output bits 25, 26, 27, 31 mapped
// R5: cmd 92/60 sets input devices
// R6: device state equals last received word
// R7: master resends bits it keeps on
// R8: input bits 0-7 mapped
// R9: input bits 8-15, 20, 27-29 mapped
// R10: cmd 90/00,10 key disables/enables inputs
// R11: disabled inputs read off, 0 V, no pulses
// R12: forced stop, stroke ends never disabled
// R13: cmd 90/03,13 key disables/enables outputs
// R14: cmd 92/00 sets test input devices
// R15: 0.5 s silence in test stops motor
// R16: master keeps polling during test
// R17: test entry while running coasts motor
// R18: cmd 8B/00 selects jog, positioning, forced
// R19: cmd 00/12 returns test mode code
// R20: cmd 8B/00 data 0000 cancels test
// R21: A0/41 STOP pauses positioning
// R22: G0 restarts, CLR clears remaining distance
// R23: replies also as hex characters
// R24: unassigned bits read zero, writes ignored
// R25: wrong key leaves state unchanged
`timescale 1ns/100ps
`include "servo_cmd_regs.svh"

module servo_io_test_cmd_handler #(
   parameter int unsigned COMM_LOSS_CYC =
      `COMM_LOSS_NS / `PCLK_PERIOD_NS
) (
   input  wire logic        pclk,              // apb clock, 200 MHz
   input  wire logic        presetn,           // async reset, low
   input  wire logic [7:0]  paddr,             // apb byte address
   input  wire logic        psel,              // apb select
   input  wire logic        penable,           // apb access phase
   input  wire logic        pwrite,            // apb write
   input  wire logic [31:0] pwdata,            // apb write data
   input  wire logic [3:0]  pstrb,             // apb byte strobes
   output logic      [31:0] prdata,            // apb read data
   output logic             pready,            // apb ready
   output logic             pslverr,           // apb error
   input  wire logic [31:0] out_dev_in,        // raw output devices
   input  wire logic [31:0] ext_di_in,         // external input pins
   input  wire logic        forced_stop_two_in,// forced stop input
   input  wire logic        motor_running,     // motor not at rest
   output logic      [31:0] di_eff,            // effective inputs
   output logic             forced_stop_two_out,// forced stop to core
   output logic             analog_zero,       // analog inputs as 0 V
   output logic             pulse_inhibit,     // pulse train ignored
   output logic      [31:0] do_out,            // output devices
   output logic             base_shutoff,      // power stage off
   output logic             decel_stop,        // decelerate to stop
   output logic             servo_lock,        // hold position
   output logic             pos_pause,         // positioning paused
   output logic             pos_restart,       // restart pulse
   output logic             pos_clear,         // clear distance pulse
   output servo_cmd_pkg::test_mode_t test_mode_out // current test mode
);
   import servo_cmd_pkg::*;

   localparam int unsigned CW = $clog2(COMM_LOSS_CYC + 1);

   logic [15:0] cmd_reg;
   logic [31:0] data_reg;
   logic [31:0] reply_reg;
   logic [31:0] comm_di_reg;
   logic [31:0] test_di_reg;
   logic        di_dis_reg;
   logic        do_dis_reg;
   logic        bad_cmd_reg;
   test_mode_t  mode_reg;
   logic        base_off_reg;
   logic        lost_reg;
   logic        pause_reg;
   logic        restart_reg;
   logic        clear_reg;
   logic [CW-1:0] idle_cnt_reg;
   logic [31:0] prdata_reg;
   logic [63:0] ascii;
   logic [31:0] src_di;
   logic        wr_acc;
   logic        rd_setup;
   logic        exec;
   logic [7:0]  op;
   logic [7:0]  dn;
   logic        mapped;
   logic        known;

   assign op     = cmd_reg[15:8];
   assign dn     = cmd_reg[7:0];
   assign wr_acc = psel & penable & pwrite;
   // register read data one cycle early so it is a flop in access
   assign rd_setup = psel & ~penable & ~pwrite;
   assign exec   = wr_acc & (paddr == `OFS_GO);

   always_comb begin
      mapped = 1'b1;
      case (paddr)
         `OFS_CMD, `OFS_DATA, `OFS_GO, `OFS_REPLY,
         `OFS_ASCII_HI, `OFS_ASCII_LO, `OFS_STATE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_reg;

   always_comb begin
      known = 1'b0;
      case (op)
         `CMD_RD_IO:    known = (dn == `DN_OUT_DEV);
         `CMD_WR_DI:    known = (dn == `DN_COMM_DI) |
                                (dn == `DN_TEST_DI);
         `CMD_DIO_EN:   known = (dn == `DN_DI_DIS) | (dn == `DN_DI_EN) |
                                (dn == `DN_DO_DIS) | (dn == `DN_DO_EN);
         `CMD_TEST_SEL: known = (dn == `DN_TEST_SEL);
         `CMD_RD_STAT:  known = (dn == `DN_TEST_MODE);
         `CMD_POS_CTL:  known = (dn == `DN_POS_CTL);
         default:       known = 1'b0;
      endcase
   end

   // command code and data number, byte strobed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_reg <= 16'h0000;
      end else if (wr_acc && paddr == `OFS_CMD) begin
         if (pstrb[0]) cmd_reg[7:0] <= pwdata[7:0];
         if (pstrb[1]) cmd_reg[15:8] <= pwdata[15:8];
      end
   end

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_data
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               data_reg[8*b+7:8*b] <= 8'h00;
            end else if (wr_acc && paddr == `OFS_DATA && pstrb[b]) begin
               data_reg[8*b+7:8*b] <= pwdata[8*b+7:8*b];
            end
         end
      end
   endgenerate

   // reply word for the read commands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_reg <= 32'h0000_0000;
      end else if (exec) begin
         if (op == `CMD_RD_IO && dn == `DN_OUT_DEV) begin
            // R1: output word reply
            // R24: unassigned bits zero
            reply_reg <= do_out;
         end else if (op == `CMD_RD_STAT && dn == `DN_TEST_MODE) begin
            // R19: test mode code
            reply_reg <= {29'h0000_0000, mode_reg};
         end
      end
   end

   // R23: reply as hex characters
   genvar n;
   generate
      for (n = 0; n < 8; n++) begin : g_hex
         logic [3:0] nib;
         assign nib = reply_reg[4*n+3:4*n];
         assign ascii[8*n+7:8*n] = (nib < 4'hA) ?
            (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_cmd_reg <= 1'b0;
      end else if (exec) begin
         bad_cmd_reg <= ~known;
      end
   end

   // communicated and test input words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comm_di_reg <= 32'h0000_0000;
         test_di_reg <= 32'h0000_0000;
      end else if (exec && op == `CMD_WR_DI) begin
         // R5: write input word
         // R6: whole word replaced
         // R24: unassigned bits dropped
         if (dn == `DN_COMM_DI)
            comm_di_reg <= data_reg & `IN_MASK;
         // R14: test input word
         if (dn == `DN_TEST_DI)
            test_di_reg <= data_reg & `IN_MASK;
      end
   end

   // input and output disable flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         di_dis_reg <= 1'b0;
         do_dis_reg <= 1'b0;
      end else if (exec && op == `CMD_DIO_EN &&
                   data_reg == `KEY_DIO) begin
         // R25: key must match
         // R10: input disable/enable
         if (dn == `DN_DI_DIS) di_dis_reg <= 1'b1;
         if (dn == `DN_DI_EN)  di_dis_reg <= 1'b0;
         // R13: output disable/enable
         if (dn == `DN_DO_DIS) do_dis_reg <= 1'b1;
         if (dn == `DN_DO_EN)  do_dis_reg <= 1'b0;
      end
   end

   // test mode selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= TM_NORMAL;
      end else if (exec && op == `CMD_TEST_SEL &&
                   dn == `DN_TEST_SEL) begin
         // R18: select test mode
         // R20: 0000 cancels
         case (data_reg)
            `SEL_CANCEL: mode_reg <= TM_NORMAL;
            `SEL_JOG:    mode_reg <= TM_JOG;
            `SEL_POS:    mode_reg <= TM_POS;
            `SEL_FORCED: mode_reg <= TM_FORCED;
            default:     mode_reg <= mode_reg;
         endcase
      end
   end

   // R17: coast on test entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_off_reg <= 1'b0;
      end else if (exec && op == `CMD_TEST_SEL && dn == `DN_TEST_SEL &&
                   mode_reg == TM_NORMAL && motor_running &&
                   (data_reg == `SEL_JOG || data_reg == `SEL_POS ||
                    data_reg == `SEL_FORCED)) begin
         base_off_reg <= 1'b1;
      end else if (!motor_running || mode_reg == TM_NORMAL) begin
         // released once the motor has coasted to rest or the test mode is back to normal
         base_off_reg <= 1'b0;
      end
   end

   // R15: communication loss watchdog
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_reg <= '0;
      end else if (exec || mode_reg == TM_NORMAL) begin
         idle_cnt_reg <= '0;
      end else if (idle_cnt_reg != CW'(COMM_LOSS_CYC)) begin
         idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
   end

   // R15: stop and servo-lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lost_reg <= 1'b0;
      end else if (mode_reg == TM_NORMAL) begin
         lost_reg <= 1'b0;
      end else if (idle_cnt_reg == CW'(COMM_LOSS_CYC)) begin
         // the lock holds until test mode is cancelled
         lost_reg <= 1'b1;
      end
   end

   // positioning temporary stop and restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_reg   <= 1'b0;
         restart_reg <= 1'b0;
         clear_reg   <= 1'b0;
      end else begin
         restart_reg <= 1'b0;
         clear_reg   <= 1'b0;
         if (mode_reg != TM_POS) begin
            pause_reg <= 1'b0;
         end else if (exec && op == `CMD_POS_CTL && dn == `DN_POS_CTL) begin
            // R21: stop keeps job
            if (data_reg == `DATA_STOP)
               pause_reg <= 1'b1;
            // R22: restart or clear
            if (pause_reg && data_reg == `DATA_GO) begin
               pause_reg   <= 1'b0;
               restart_reg <= 1'b1;
            end
            if (pause_reg && data_reg == `DATA_CLR) begin
               pause_reg <= 1'b0;
               clear_reg <= 1'b1;
            end
         end
      end
   end

   // apb read data, captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr)
            `OFS_CMD:      prdata_reg <= {16'h0000, cmd_reg};
            `OFS_DATA:     prdata_reg <= data_reg;
            `OFS_GO:       prdata_reg <= {31'h0000_0000, bad_cmd_reg};
            `OFS_REPLY:    prdata_reg <= reply_reg;
            `OFS_ASCII_HI: prdata_reg <= ascii[63:32];
            `OFS_ASCII_LO: prdata_reg <= ascii[31:0];
            `OFS_STATE:    prdata_reg <= {22'h00_0000, mode_reg,
                                          pause_reg, lost_reg,
                                          base_off_reg, do_dis_reg,
                                          di_dis_reg, 2'b00};
            default:       prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // test word replaces the communicated word while testing
   assign src_di = (mode_reg == TM_NORMAL) ? comm_di_reg : test_di_reg;

   always_comb begin
      if (di_dis_reg) begin
         // R11: disabled inputs off
         // R12: stroke ends still live
         di_eff = ext_di_in & `STROKE_MASK;
      end else begin
         // R8: input layout
         // R9: upper input layout
         di_eff = (ext_di_in | src_di) & `IN_MASK;
      end
   end

   // R12: forced stop passthrough
   assign forced_stop_two_out = forced_stop_two_in;
   // R11: analog and pulse disable
   assign analog_zero   = di_dis_reg;
   assign pulse_inhibit = di_dis_reg;

   // R2: lower output bits
   // R3: middle output bits
   // R4: upper output bits
   // R13: disabled outputs off
   assign do_out = do_dis_reg ? 32'h0000_0000 : (out_dev_in & `OUT_MASK);

   assign base_shutoff  = base_off_reg;
   assign decel_stop    = lost_reg | pause_reg;
   assign servo_lock    = lost_reg;
   assign pos_pause     = pause_reg;
   assign pos_restart   = restart_reg;
   assign pos_clear     = clear_reg;
   assign test_mode_out = mode_reg;
endmodule

// ===== servo_cmd_monitor.sv
// assertion checker bound to the command handler ports
`timescale 1ns/100ps
`include "servo_cmd_regs.svh"
module servo_cmd_monitor
   import servo_cmd_pkg::*;
#(
   parameter int unsigned COMM_LOSS_CYC = 50
) (
   input wire logic        pclk,                // clock
   input wire logic        presetn,             // reset, low
   input wire logic [7:0]  paddr,               // apb address
   input wire logic        psel,                // apb select
   input wire logic        penable,             // apb access
   input wire logic        pwrite,              // apb write
   input wire logic        pready,              // apb ready
   input wire logic [31:0] out_dev_in,          // raw outputs
   input wire logic [31:0] ext_di_in,           // raw inputs
   input wire logic        forced_stop_two_in,  // stop pin
   input wire logic [31:0] di_eff,              // inputs used
   input wire logic        forced_stop_two_out, // stop to core
   input wire logic        analog_zero,         // analog off
   input wire logic        pulse_inhibit,       // pulses off
   input wire logic [31:0] do_out,              // outputs
   input wire logic        decel_stop,          // stopping
   input wire logic        servo_lock,          // locked
   input wire logic        pos_pause,           // paused
   input wire logic        pos_restart,         // restart pulse
   input wire logic        pos_clear,           // clear pulse
   input servo_cmd_pkg::test_mode_t test_mode_out // mode
);
   logic [31:0] quiet_reg;
   wire         go_hit = psel && penable && pwrite && paddr == `OFS_GO;
   // cycles since the last executed command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         quiet_reg <= '0;
      else if (go_hit)
         quiet_reg <= '0;
      else
         quiet_reg <= quiet_reg + 32'h1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence no_go;
      !go_hit;
   endsequence
   chk_stop_two_pass: assert property (forced_stop_two_out == forced_stop_two_in)
      else $error("forced stop output differs from its pin");
   chk_out_word_map: assert property (do_out == '0 || do_out == (out_dev_in & `OUT_MASK))
      else $error("output word not the masked device states");
   chk_in_disabled: assert property (analog_zero |-> di_eff == (ext_di_in & `STROKE_MASK))
      else $error("disabled inputs not forced off");
   chk_in_unassigned: assert property ((di_eff & ~`IN_MASK) == '0)
      else $error("unassigned input bit set");
   chk_analog_pulse: assert property (analog_zero == pulse_inhibit)
      else $error("analog and pulse disable disagree");
   chk_lock_stops: assert property (servo_lock |-> decel_stop)
      else $error("lock without deceleration");
   chk_pause_stops: assert property (pos_pause |-> decel_stop)
      else $error("pause without deceleration");
   chk_pulse_single: assert property ((pos_restart || pos_clear) |=> !pos_restart && !pos_clear)
      else $error("restart or clear pulse too long");
   chk_mode_by_cmd: assert property (no_go |=> $stable(test_mode_out) && !$rose(pos_pause))
      else $error("mode or pause changed without a command");
   chk_lock_timing: assert property ($rose(servo_lock) |-> quiet_reg + 2 >= COMM_LOSS_CYC && quiet_reg <= COMM_LOSS_CYC + 2)
      else $error("lock not at the silence limit");
   chk_mode_legal: assert property (test_mode_out inside {TM_NORMAL, TM_JOG, TM_POS, TM_FORCED})
      else $error("illegal test mode");
endmodule
bind servo_io_test_cmd_handler servo_cmd_monitor #(
   .COMM_LOSS_CYC(COMM_LOSS_CYC)
) u_mon (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pready,
   .out_dev_in, .ext_di_in, .forced_stop_two_in, .di_eff,
   .forced_stop_two_out, .analog_zero, .pulse_inhibit, .do_out,
   .decel_stop, .servo_lock, .pos_pause, .pos_restart, .pos_clear,
   .test_mode_out);

// ===== servo_motor_model.sv
// motor and pin side of the handler: raw devices and a coasting motor
`timescale 1ns/100ps
module servo_motor_model (
   input  wire logic        pclk,               // clock
   input  wire logic        presetn,            // reset, low
   input  wire logic        spin,               // run request
   input  wire logic        base_shutoff,       // power stage off
   input  wire logic        decel_stop,         // stop request
   input  wire logic [31:0] out_pat,            // device states
   input  wire logic [31:0] di_pat,             // pin states
   input  wire logic        stop_two,           // stop pin
   output logic      [31:0] out_dev_in,         // to handler
   output logic      [31:0] ext_di_in,          // to handler
   output logic             forced_stop_two_in, // to handler
   output logic             motor_running       // motor turning
);
   logic [2:0] coast_reg;
   assign out_dev_in = out_pat;
   assign ext_di_in = di_pat;
   assign forced_stop_two_in = stop_two;
   // stays at rest once stopped until run is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coast_reg <= '0;
         motor_running <= 1'b0;
      end else if (!spin) begin
         coast_reg <= '0;
         motor_running <= 1'b0;
      end else if (base_shutoff || decel_stop || coast_reg != 3'h0) begin
         coast_reg <= (coast_reg == 3'h4) ? coast_reg : coast_reg + 3'h1;
         if (coast_reg == 3'h3)
            motor_running <= 1'b0;
      end else
         motor_running <= 1'b1;
   end
endmodule

// ===== servo_io_test_cmd_handler_tb_top.sv
// self-checking bench for the servo i/o and test command handler
`timescale 1ns/100ps
`include "servo_cmd_regs.svh"
module servo_io_test_cmd_handler_tb_top;
   import servo_cmd_pkg::*;
   localparam int unsigned LOSS = 50;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, stop_two = 1'b0, spin = 1'b0, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = '0, out_pat = 32'hFFFF_FFFF, di_pat = '0, rd;
   logic [31:0] prdata, out_dev_in, ext_di_in, di_eff, do_out;
   logic        pready, pslverr, forced_stop_two_in, forced_stop_two_out;
   logic        motor_running, analog_zero, pulse_inhibit, base_shutoff;
   logic        decel_stop, servo_lock, pos_pause, pos_restart, pos_clear;
   test_mode_t  test_mode_out;
   logic [31:0] sel [3] = '{`SEL_JOG, `SEL_POS, `SEL_FORCED};
   int          error_cnt = 0, n_tests = 0, cyc = 0, n_rst = 0, n_clr = 0;
   servo_io_test_cmd_handler #(.COMM_LOSS_CYC(LOSS)) u_dut (.pclk,
      .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
      .prdata, .pready, .pslverr, .out_dev_in, .ext_di_in,
      .forced_stop_two_in, .motor_running, .di_eff, .forced_stop_two_out,
      .analog_zero, .pulse_inhibit, .do_out, .base_shutoff, .decel_stop,
      .servo_lock, .pos_pause, .pos_restart, .pos_clear, .test_mode_out);
   servo_motor_model u_motor (.pclk, .presetn, .spin, .base_shutoff,
      .decel_stop, .out_pat, .di_pat, .stop_two, .out_dev_in, .ext_di_in,
      .forced_stop_two_in, .motor_running);
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   task automatic test_done;
      if (error_cnt == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard, also counts the one-cycle pulses
   always @(posedge pclk) begin
      cyc++;
      if (pos_restart === 1'b1)
         n_rst++;
      if (pos_clear === 1'b1)
         n_clr++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // one command: code, data number, data word, then execute
   task automatic cmd(input logic [7:0] c, dn, input logic [31:0] d);
      apb(1'b1, `OFS_CMD, {16'h0000, c, dn});
      apb(1'b1, `OFS_DATA, d);
      apb(1'b1, `OFS_GO, '0);
      @(negedge pclk);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      cmd(`CMD_RD_IO, `DN_OUT_DEV, '0);
      apb(1'b0, `OFS_REPLY, '0);
      chk("out word", rd, `OUT_MASK);
      apb(1'b0, `OFS_ASCII_HI, '0);
      chk("text hi", rd, 32'h3845_3030);
      apb(1'b0, `OFS_ASCII_LO, '0);
      chk("text lo", rd, 32'h4646_4246);
      for (int i = 0; i < 32; i++) begin
         cmd(`CMD_WR_DI, `DN_COMM_DI, 32'h0000_0001 << i);
         chk("in bit", di_eff, (32'h0000_0001 << i) & `IN_MASK);
      end
      @(posedge pclk);
      di_pat <= 32'hFFFF_FFFF;
      cmd(`CMD_DIO_EN, `DN_DI_DIS, 32'h0000_1EA4);
      chk("bad key", {31'h0, analog_zero}, '0);
      cmd(`CMD_DIO_EN, `DN_DI_DIS, `KEY_DIO);
      chk("in off", di_eff, `STROKE_MASK);
      chk("analog", {30'h0, analog_zero, pulse_inhibit}, 32'h3);
      @(posedge pclk);
      stop_two <= 1'b1;
      @(negedge pclk);
      chk("stop two", {31'h0, forced_stop_two_out}, 32'h1);
      cmd(`CMD_DIO_EN, `DN_DI_EN, `KEY_DIO);
      chk("in on", di_eff, `IN_MASK);
      cmd(`CMD_DIO_EN, `DN_DO_DIS, `KEY_DIO);
      chk("out off", do_out, '0);
      cmd(`CMD_DIO_EN, `DN_DO_EN, `KEY_DIO);
      chk("out on", do_out, `OUT_MASK);
      foreach (sel[i]) begin
         cmd(`CMD_TEST_SEL, `DN_TEST_SEL, sel[i]);
         cmd(`CMD_TEST_SEL, `DN_TEST_SEL, 32'h0000_0003);
         cmd(`CMD_RD_STAT, `DN_TEST_MODE, '0);
         apb(1'b0, `OFS_REPLY, '0);
         chk("mode code", rd, sel[i]);
         cmd(`CMD_TEST_SEL, `DN_TEST_SEL, `SEL_CANCEL);
         chk("cancel", {29'h0, test_mode_out}, '0);
      end
      @(posedge pclk);
      di_pat <= '0;
      cmd(`CMD_TEST_SEL, `DN_TEST_SEL, `SEL_JOG);
      cmd(`CMD_WR_DI, `DN_TEST_DI, 32'hC000_1801);
      chk("test in", di_eff, 32'h0000_1801);
      cmd(`CMD_POS_CTL, `DN_POS_CTL, `DATA_STOP);
      chk("jog stop", {31'h0, pos_pause}, '0);
      repeat (6) begin
         repeat (30) @(posedge pclk);
         cmd(`CMD_RD_STAT, `DN_TEST_MODE, '0);
      end
      chk("no loss", {31'h0, servo_lock}, '0);
      repeat (LOSS + 5) @(posedge pclk);
      @(negedge pclk);
      chk("loss", {30'h0, servo_lock, decel_stop}, 32'h3);
      cmd(`CMD_TEST_SEL, `DN_TEST_SEL, `SEL_CANCEL);
      // lock still sees the old mode at the cancel edge
      @(negedge pclk);
      chk("unlock", {31'h0, servo_lock}, '0);
      @(posedge pclk);
      spin <= 1'b1;
      repeat (3) @(posedge pclk);
      cmd(`CMD_TEST_SEL, `DN_TEST_SEL, `SEL_POS);
      chk("coast", {31'h0, base_shutoff}, 32'h1);
      cmd(`CMD_POS_CTL, `DN_POS_CTL, `DATA_STOP);
      chk("pause", {30'h0, pos_pause, decel_stop}, 32'h3);
      cmd(`CMD_POS_CTL, `DN_POS_CTL, `DATA_GO);
      chk("go", {31'h0, pos_pause}, '0);
      cmd(`CMD_POS_CTL, `DN_POS_CTL, `DATA_STOP);
      cmd(`CMD_POS_CTL, `DN_POS_CTL, `DATA_CLR);
      chk("clr", {30'h0, pos_pause, base_shutoff}, '0);
      // clear pulse is counted on the following edge
      @(negedge pclk);
      chk("pulses", {n_rst[15:0], n_clr[15:0]}, 32'h0001_0001);
      apb(1'b0, 8'h1C, '0);
      chk("hole", {rd[30:0], err}, 32'h1);
      cmd(`CMD_TEST_SEL, `DN_TEST_SEL, `SEL_CANCEL);
      test_done();
   end
endmodule
